// ### dv/rcw_cfg_buffers.sv
// Board buffer model for the data bus during reset
`timescale 1ns/1ps
`default_nettype none
module rcw_cfg_buffers (
    input wire logic clk_sys,
    input wire logic drive,
    input wire logic resetOutputN,
    input wire logic [31:0] word,
    output logic [31:0] dataBusIn = 32'h5a5a_a5a5
);
    // Released bus toggles, so a late latch cannot pass by luck
    always_ff @(posedge clk_sys) begin
        dataBusIn <= (drive && !resetOutputN) ? word : ~dataBusIn;
    end
endmodule
`default_nettype wire

// ### dv/rcw_latch_monitor.sv
// Assertions on the reset configuration word latch ports
`timescale 1ns/1ps
`default_nettype none
module rcw_latch_monitor (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic resetRequest,
    input wire logic debugSerialIn,
    input wire logic synthLocked,
    input wire logic synthSupplyStrap,
    input wire logic clockModeStrap,
    input wire logic resetOutputN,
    input wire logic [2:0] bootWaitStates,
    input wire logic [1:0] instrMemBase,
    input wire logic [1:0] sramBlockBase,
    input wire logic localMemEnable,
    input wire logic testSlaveEnable
);
    // One domain; ranges allow two clocks of release pipeline
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    hold_in_reset_a: assert property (resetRequest |=> !resetOutputN)
        else $error("released while held");
    no_early_release_a: assert property ($fell(resetRequest) |-> !resetOutputN [*8])
        else $error("released too early");
    fixed_delay_a: assert property ($fell(resetRequest) && !synthSupplyStrap
        |-> ##[15:20] resetOutputN) else $error("bypass release late");
    locked_delay_a: assert property ($fell(resetRequest) && synthSupplyStrap
        && synthLocked |-> ##[15:20] resetOutputN) else $error("locked release late");
    one_to_one_a: assert property (synthSupplyStrap && !clockModeStrap
        && !synthLocked && !resetOutputN |=> !resetOutputN) else $error("released unlocked");
    config_stable_a: assert property (resetOutputN && $past(resetOutputN)
        |-> $stable({bootWaitStates, instrMemBase, sramBlockBase, localMemEnable}))
        else $error("config changed");
    default_word_a: assert property ($rose(resetOutputN) && !debugSerialIn
        |-> bootWaitStates == 3'h7 && localMemEnable && !testSlaveEnable)
        else $error("default word wrong");
    default_place_a: assert property ($rose(resetOutputN) && !debugSerialIn
        |-> instrMemBase == 2'h1 && sramBlockBase == 2'h3) else $error("default bases");
    cover property ($rose(resetOutputN) && debugSerialIn);
    cover property ($rose(resetOutputN) && !synthLocked && clockModeStrap);
    cover property ($fell(resetRequest) && !clockModeStrap);
endmodule
bind rcw_latch rcw_latch_monitor u_monitor (
    .clk_sys, .rstn, .resetRequest, .debugSerialIn, .synthLocked, .synthSupplyStrap,
    .clockModeStrap, .resetOutputN, .bootWaitStates, .instrMemBase, .sramBlockBase,
    .localMemEnable, .testSlaveEnable
);
`default_nettype wire

// ### dv/tb_reset_config_word_latch.sv
// Self-checking bench for the reset configuration word latch
`timescale 1ns/1ps
`default_nettype none
module tb_reset_config_word_latch;
    // Default word with bit 0 at the MSB
    localparam logic [31:0] DEF_WORD = 32'h03bb_f0a3;
    logic clk_sys = 0, rstn = 0, resetRequest = 1, debugSerialIn = 0, bufDrive = 0;
    logic resetSourceExternal = 1, synthLocked = 0, synthSupplyStrap = 1, clockModeStrap = 1;
    logic hsel = 0, hwrite = 0, hreadyout, hresp, resetOutputN;
    logic [1:0] htrans = 2'h0, instrMemBase, sramBlockBase;
    logic [2:0] hsize = 3'h2, bootWaitStates;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, dataBusIn, bufWord = 32'h0, rd;
    logic busCyc, busWr, dbgTrk, hshk, arb, lmem, prm, upAddr, tSlave, tTrans;
    int check_count = 0, fail_count = 0, nExt, nInt;
    rcw_latch #(.TIMEOUT_CYCLES(32)) DUT (
        .clk_sys, .rstn, .resetRequest, .resetSourceExternal, .debugSerialIn, .dataBusIn,
        .synthLocked, .synthSupplyStrap, .clockModeStrap, .resetOutputN, .bootWaitStates,
        .instrMemBase, .sramBlockBase, .busCycleTypePins(busCyc), .busWriteBurstPins(busWr),
        .debugTrackPins(dbgTrk), .handshakePins(hshk), .arbitrationPins(arb),
        .localMemEnable(lmem), .portReplacementMode(prm), .upperAddrPins(upAddr),
        .testSlaveEnable(tSlave), .testTransparentEnable(tTrans), .hsel, .haddr, .htrans,
        .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata
    );
    rcw_cfg_buffers u_buf (.clk_sys, .drive(bufDrive), .resetOutputN, .word(bufWord),
        .dataBusIn);
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Later groups only follow the pins when the group before says so
    function automatic logic [31:0] expWord(input logic [31:0] bus, input logic ext);
        logic [31:0] w;
        w = DEF_WORD;
        if (ext) w[31:26] = bus[31:26];
        if (ext && w[26]) w[25:18] = bus[25:18];
        if (ext && w[18]) w[17:10] = bus[17:10];
        if (ext && w[10]) w[9:0] = bus[9:0];
        return w;
    endfunction
    // Single AHB word transfer; waits on hready, no fixed latency assumed
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= addr;
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
        check("hresp", 32'(hresp), 32'h0);
    endtask
    // Soft reset through the control register; internal source, so the short delay
    task automatic soft_run();
        logic [31:0] w;
        int n;
        w = expWord(bufWord, debugSerialIn);
        ahb(1'b1, 32'h8, 32'h1);
        repeat (2) @(posedge clk_sys);
        check("soft hold", 32'(resetOutputN), 32'h0);
        n = 0;
        while (resetOutputN !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        check("soft delay", 32'(n >= 15 && n <= 18), 32'h1);
        check("soft config", 32'({bootWaitStates, instrMemBase, sramBlockBase, busCyc, busWr,
            dbgTrk, hshk, arb, lmem, prm, upAddr, tSlave, tTrans}),
            32'({w[25:19], w[17:13], w[7:5], ~w[1:0]}));
        ahb(1'b0, 32'h4, 32'h0);
        check("status", rd, 32'h5);
    endtask
    // One reset request; n counts clocks from its fall to release
    task automatic run(input logic debug_serial_in, input logic [31:0] bus, input logic [2:0] mode,
        input int lockAt, output int n);
        logic [31:0] w;
        w = expWord(bus, debug_serial_in);
        @(posedge clk_sys);
        resetRequest <= 1'b1;
        debugSerialIn <= debug_serial_in;
        bufDrive <= debug_serial_in;
        bufWord <= bus;
        {resetSourceExternal, synthSupplyStrap, clockModeStrap} <= mode;
        synthLocked <= (lockAt == 0);
        repeat (4) @(posedge clk_sys);
        resetRequest <= 1'b0;
        n = 0;
        while (resetOutputN !== 1'b1 && n < 100) begin
            @(posedge clk_sys);
            n++;
            if (n == lockAt) synthLocked <= 1'b1;
        end
        check("config", 32'({bootWaitStates, instrMemBase, sramBlockBase, busCyc, busWr, dbgTrk,
            hshk, arb, lmem, prm, upAddr, tSlave, tTrans}),
            32'({w[25:19], w[17:13], w[7:5], ~w[1:0]}));
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        run(0, 32'hffff_ffff, 3'b111, 999, nExt);
        check("ext delay", 32'(nExt >= 17 && nExt <= 20), 32'h1);
        run(0, 32'hffff_ffff, 3'b011, 999, nInt);
        check("delay gap", 32'(nExt - nInt), 32'h2);
        ahb(1'b1, 32'h0, 32'hffff_ffff);
        ahb(1'b0, 32'h0, 32'h0);
        check("word reg", rd, DEF_WORD);
        ahb(1'b0, 32'hc, 32'h0);
        check("unmapped", rd, 32'h0);
        run(1, 32'h15a4_5ae5 | 32'h0404_1400, 3'b111, 0, nExt);
        run(1, 32'hfbff_ffff, 3'b111, 0, nExt);
        run(1, 32'hffff_ebff, 3'b111, 999, nExt);
        check("timeout", 32'(nExt >= 32 && nExt <= 40), 32'h1);
        run(0, 32'h0, 3'b110, 40, nExt);
        check("one to one", 32'(nExt >= 40 && nExt <= 44), 32'h1);
        run(1, 32'hffff_ebff, 3'b101, 999, nExt);
        check("bypass", 32'(nExt >= 17 && nExt <= 20), 32'h1);
        soft_run();
        tally_and_finish();
    end
    // Hang guard well past the few hundred clocks the runs need
    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ### rtl/rcw_latch.sv
// Reset configuration word latch and internal reset release timer
// Contract
// - External word when debug serial in high
// - Latch word when internal reset negates
// - Bits 6-8 set boot wait states
// - Bits 9-10 place instruction memory
// - Bits 11-12 place SRAM block
// - Bits 5, 13, 21 select next group source
// - Bits 17,18 select handshake, arbitration pins
// - Bit 19 set: release after 15/17
// - Normal, bit 19 clear: lock or timeout
// - Clock mode from two straps
// - One-to-one mode waits lock plus delay
// - Bypass/test: release after fixed delay
// - Bit 24 enables local memory
// - Bit 25 redirects port accesses externally
// - Bits 30,31 low enable test modes
//
// Implementation choices: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rcw_latch
    import rcw_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = 16384
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic resetRequest,
    input wire logic resetSourceExternal,
    input wire logic debugSerialIn,
    input wire logic [31:0] dataBusIn,
    input wire logic synthLocked,
    input wire logic synthSupplyStrap,
    input wire logic clockModeStrap,
    output logic resetOutputN,
    output logic [2:0] bootWaitStates,
    output logic [1:0] instrMemBase,
    output logic [1:0] sramBlockBase,
    output logic busCycleTypePins,
    output logic busWriteBurstPins,
    output logic debugTrackPins,
    output logic handshakePins,
    output logic arbitrationPins,
    output logic localMemEnable,
    output logic portReplacementMode,
    output logic upperAddrPins,
    output logic testSlaveEnable,
    output logic testTransparentEnable,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);
    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic rstMeta, rstSync;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end

    // Bit n counted from the MSB, as the configuration word numbers them
    function automatic logic cwBit(input logic [31:0] w, input int unsigned n);
        return w[31 - n];
    endfunction

    // ------------------------------------------------------------
    // Word assembly
    // ------------------------------------------------------------
    logic [31:0] assembled;
    always_comb begin
        assembled = CW_DEFAULT;
        if (debugSerialIn) begin
            // Groups after the first taken from the pins only if the prior group's last bit asks
            assembled[31:26] = dataBusIn[31:26];
            if (cwBit(dataBusIn, BIT_SRC_GRP1)) begin
                assembled[25:18] = dataBusIn[25:18];
                if (cwBit(dataBusIn, BIT_SRC_GRP2)) begin
                    assembled[17:10] = dataBusIn[17:10];
                    if (cwBit(dataBusIn, BIT_SRC_GRP3)) begin
                        assembled[9:0] = dataBusIn[9:0];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Clock mode and release sequencing
    // ------------------------------------------------------------
    rcw_clk_mode_t clkMode;
    assign clkMode = rcw_clk_mode_t'({synthSupplyStrap, clockModeStrap});

    rcw_state_t state;
    logic [4:0] delayCnt;
    logic [4:0] delayTarget;
    logic [31:0] timeoutCnt;
    logic delayDone, timedOut, releaseNow, extSrcReg;
    logic [31:0] softCtrl;
    logic softReset;
    logic [31:0] cfgWord;

    assign softReset = softCtrl[0];
    assign delayTarget = extSrcReg ? DELAY_EXTERNAL : DELAY_INTERNAL;
    assign delayDone = (delayCnt >= delayTarget);
    assign timedOut = (timeoutCnt >= TIMEOUT_CYCLES);

    // Release decision depends on mode; bit 19 of the assembled word is used live
    always_comb begin
        unique case (clkMode)
            CLK_NORMAL: begin
                if (cwBit(assembled, BIT_RELEASE_DIRECT)) begin
                    releaseNow = delayDone;
                end else begin
                    releaseNow = (synthLocked && delayDone) || timedOut;
                end
            end
            CLK_ONE_TO_ONE: releaseNow = synthLocked && delayDone;
            CLK_SYNTH_BYPASS, CLK_SPECIAL_TEST: releaseNow = delayDone;
        endcase
    end

    // Sequencer: hold while reset requested, count after negation
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            state <= ST_HOLD;
            delayCnt <= 5'h00;
            timeoutCnt <= 32'h0000_0000;
            extSrcReg <= 1'b1;
        end else if (resetRequest || softReset) begin
            state <= ST_HOLD;
            delayCnt <= 5'h00;
            timeoutCnt <= 32'h0000_0000;
            extSrcReg <= resetRequest && resetSourceExternal;
        end else begin
            unique case (state)
                ST_HOLD: state <= ST_COUNT;
                ST_COUNT: begin
                    if (!delayDone) delayCnt <= delayCnt + 5'h01;
                    if (!timedOut) timeoutCnt <= timeoutCnt + 32'h0000_0001;
                    if (releaseNow) state <= ST_DONE;
                end
                ST_DONE: state <= ST_DONE;
            endcase
        end
    end

    // Word captured on the edge that negates internal reset
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            cfgWord <= CW_DEFAULT;
        end else if (state == ST_COUNT && releaseNow && !resetRequest && !softReset) begin
            cfgWord <= assembled;
        end
    end

    // Internal reset reflected on the reset output
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            resetOutputN <= 1'b0;
        end else begin
            resetOutputN <= (state == ST_COUNT && releaseNow && !resetRequest && !softReset)
                || (state == ST_DONE && !resetRequest && !softReset);
        end
    end

    // ------------------------------------------------------------
    // Decoded configuration outputs
    // ------------------------------------------------------------
    assign bootWaitStates = cfgWord[25:23];
    assign instrMemBase = cfgWord[22:21];
    assign sramBlockBase = cfgWord[20:19];
    assign busCycleTypePins = cwBit(cfgWord, 14);
    assign busWriteBurstPins = cwBit(cfgWord, 15);
    assign debugTrackPins = cwBit(cfgWord, 16);
    assign upperAddrPins = cwBit(cfgWord, 26);
    assign handshakePins = cwBit(cfgWord, 17);
    assign arbitrationPins = cwBit(cfgWord, 18);
    assign localMemEnable = cwBit(cfgWord, 24);
    assign portReplacementMode = cwBit(cfgWord, 25);
    // Active low in the word, so enables invert
    assign testSlaveEnable = !cwBit(cfgWord, 30);
    assign testTransparentEnable = !cwBit(cfgWord, 31);

    // ------------------------------------------------------------
    // AHB-Lite slave, zero wait states
    // ------------------------------------------------------------
    logic dpValid, dpWrite;
    logic [7:0] dpAddr;
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            dpValid <= 1'b0;
            dpWrite <= 1'b0;
            dpAddr <= 8'h00;
        end else if (hready) begin
            dpValid <= hsel && htrans[1];
            dpWrite <= hwrite;
            dpAddr <= haddr[7:0];
        end
    end

    // Control: bit 0 is a software reset request, self-clearing on restart
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            softCtrl <= CTRL_RESET;
        end else if (dpValid && dpWrite && dpAddr == OFF_CTRL) begin
            softCtrl <= {31'h0000_0000, hwdata[0]};
        end else if (softReset) begin
            softCtrl <= CTRL_RESET;
        end
    end

    // Read data registered in the address phase
    always_ff @(posedge clk_sys or negedge rstSync) begin
        if (!rstSync) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                OFF_CFG_WORD: hrdata <= cfgWord;
                OFF_STATUS: hrdata <= {28'h0000_000, clkMode, synthLocked, resetOutputN};
                OFF_CTRL: hrdata <= softCtrl;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    logic unusedBits;
    assign unusedBits = ^{hsize, haddr[31:8], hwdata[31:1]};
endmodule
`default_nettype wire

// ### rtl/rcw_pkg.sv
// Package with constants for the reset configuration word latch
package rcw_pkg;
    // Configuration word bit positions (bit 0 is the MSB of the data bus)
    localparam int unsigned CW_WIDTH = 32;
    localparam int unsigned BIT_SRC_GRP1 = 5;
    localparam int unsigned BIT_SRC_GRP2 = 13;
    localparam int unsigned BIT_SRC_GRP3 = 21;
    localparam int unsigned BIT_RELEASE_DIRECT = 19;
    // Internal default word, bits 0..31 from the MSB down; bits 0..5 left out as zero
    localparam logic [31:0] CW_DEFAULT = 32'h03bb_f0a3;
    // Release delays after reset negation, in clocks
    localparam logic [4:0] DELAY_INTERNAL = 5'h0f;
    localparam logic [4:0] DELAY_EXTERNAL = 5'h11;
    // Register map
    localparam logic [7:0] OFF_CFG_WORD = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_CTRL = 8'h08;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    typedef enum logic [1:0] {
        CLK_SPECIAL_TEST,
        CLK_SYNTH_BYPASS,
        CLK_ONE_TO_ONE,
        CLK_NORMAL
    } rcw_clk_mode_t;
    typedef enum {
        ST_HOLD,
        ST_COUNT,
        ST_DONE
    } rcw_state_t;
endpackage
